// file: rtl/trbio_top.sv
// Purpose: Register B I/O control of timer channels 1 to 3, APB slave
// Assumes: Counters and cascade events come from timer logic on pclk
// Notes: Each APB access takes one wait state; unmapped addresses give pslverr
//        and zero read data, and change no register
//
// Functional notes
// - Bit7 zero: compare; 00 disables, else start 0
// - Compare with bit6 set starts pin at 1
// - Action 01 drives pin low on match
// - Action 10 drives pin high on match
// - Action 11 toggles pin on match
// - Code 1000 captures on own pin rising edge
// - Code 1001 captures on pin falling edge
// - Codes 101x capture on both pin edges
// - Channel 1 11xx captures on channel 0 event
// - Channel 2 capture ignores bit6, always pin source
// - Channel 3 11xx captures on channel 4 counts
// - Channel 4 undivided clock blocks cascaded capture
// - Channel 1 pin codes use own pin

`timescale 1ns/1ps
`default_nettype none

module trbio_top #(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer counters
    input wire logic [CNT_W-1:0] ch1_counter,
    input wire logic [CNT_W-1:0] ch2_counter,
    input wire logic [CNT_W-1:0] ch3_counter,
    // Cascade sources
    input wire logic ch0_general_reg_c_evt,
    input wire logic ch4_counter_up,
    input wire logic ch4_counter_down,
    // Pins
    input wire logic ch1_pin_b_in,
    output logic ch1_pin_b_out,
    output logic ch1_pin_b_oe,
    input wire logic ch2_pin_b_in,
    output logic ch2_pin_b_out,
    output logic ch2_pin_b_oe,
    input wire logic ch3_pin_b_in,
    output logic ch3_pin_b_out,
    output logic ch3_pin_b_oe,
    // Interrupt
    output logic irq
);

    // ******************************************************
    // Address decode
    // ******************************************************
    // Returns one-hot select: 0..2 io, 3 prescale, 4..6 reg B, 7 status, 8 mask
    function automatic logic [8:0] reg_sel(input logic [11:0] a);
        logic [8:0] s;
        s = 9'h000;
        unique case (a)
            trbio_pkg::OFF_CH1_IO_CONTROL: s = 9'h001;
            trbio_pkg::OFF_CH2_IO_CONTROL: s = 9'h002;
            trbio_pkg::OFF_CH3_IO_CONTROL_HIGH: s = 9'h004;
            trbio_pkg::OFF_CH4_COUNTER_CONTROL: s = 9'h008;
            trbio_pkg::OFF_CH1_GENERAL_REG_B: s = 9'h010;
            trbio_pkg::OFF_CH2_GENERAL_REG_B: s = 9'h020;
            trbio_pkg::OFF_CH3_GENERAL_REG_B: s = 9'h040;
            trbio_pkg::OFF_IRQ_STATUS: s = 9'h080;
            trbio_pkg::OFF_IRQ_MASK: s = 9'h100;
            default: s = 9'h000;
        endcase
        return s;
    endfunction

    // ******************************************************
    // State
    // ******************************************************
    logic [7:0] io_ff [3];
    logic [7:0] nxt_io [3];
    logic [2:0] io_wr_ff;
    logic [2:0] nxt_io_wr;
    logic [2:0] presc_ff;
    logic [2:0] nxt_presc;
    logic [5:0] stat_ff;
    logic [5:0] nxt_stat;
    logic [5:0] mask_ff;
    logic [5:0] nxt_mask;
    logic irq_ff;
    logic nxt_irq;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [8:0] sel;
    logic wr_go;
    logic [2:0] regb_wr;

    logic [CNT_W-1:0] cnt [3];
    logic [CNT_W-1:0] regb [3];
    logic [2:0] pin_in;
    logic [2:0] pin_lvl;
    logic [2:0] cas;
    logic [2:0] cap;
    logic [2:0] cmp;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;

    assign cnt[0] = ch1_counter;
    assign cnt[1] = ch2_counter;
    assign cnt[2] = ch3_counter;
    assign pin_in = {ch3_pin_b_in, ch2_pin_b_in, ch1_pin_b_in};
    assign cas[0] = ch0_general_reg_c_evt;
    assign cas[1] = 1'b0;
    // Undivided channel 4 clock makes the cascade invalid
    assign cas[2] = (ch4_counter_up | ch4_counter_down)
                    & (presc_ff != trbio_pkg::PRESCALE_UNDIVIDED);

    // ******************************************************
    // Channels
    // ******************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ch
            trbio_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(pin_in[gi]),
                .level(pin_lvl[gi])
            );
            trbio_chan #(
                .CNT_W(CNT_W),
                .CAS_IGNORE(gi == 1)
            ) u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .io_field(io_ff[gi][trbio_pkg::IO_FIELD_LSB +: trbio_pkg::IO_FIELD_W]),
                .io_wr(io_wr_ff[gi]),
                .counter(cnt[gi]),
                .regb_wdata(pwdata[CNT_W-1:0]),
                .regb_wr(regb_wr[gi]),
                .pin_lvl(pin_lvl[gi]),
                .cas_evt(cas[gi]),
                .regb(regb[gi]),
                .cap_evt(cap[gi]),
                .cmp_evt(cmp[gi]),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi])
            );
        end
    endgenerate

    // ******************************************************
    // APB response
    // ******************************************************
    // Every access answers after exactly one wait state, whatever the
    // address, so bus timing never depends on the register map
    always_comb
    begin
        sel = reg_sel(paddr);
        // Write lands at the edge where pready is seen high
        wr_go = psel & penable & pready_ff & pwrite & ~pslverr_ff;
        regb_wr = wr_go ? sel[6:4] : 3'h0;
        nxt_pready = psel & penable & ~pready_ff;
        nxt_pslverr = nxt_pready & (sel == 9'h000);
        nxt_prdata = prdata_ff;
        // A refused access of either direction returns zero data
        if (nxt_pready & (~pwrite | nxt_pslverr))
        begin
            nxt_prdata = trbio_pkg::RST_RDATA;
            for (int i = 0; i < 3; i++)
            begin
                if (sel[i])
                    nxt_prdata = {24'h000000, io_ff[i]};
                if (sel[4+i])
                    nxt_prdata = {{(32-CNT_W){1'b0}}, regb[i]};
            end
            if (sel[3])
                nxt_prdata = {29'h0000000, presc_ff};
            if (sel[7])
                nxt_prdata = {26'h0000000, stat_ff};
            if (sel[8])
                nxt_prdata = {26'h0000000, mask_ff};
        end
    end

    // Read data keeps its last value; only a read or a refusal moves it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= trbio_pkg::RST_RDATA;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // ******************************************************
    // Configuration registers
    // ******************************************************
    // The write strobe of each io register is kept one cycle so the
    // channel applies the initial level from the value just stored
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            nxt_io[i] = io_ff[i];
            nxt_io_wr[i] = wr_go & sel[i];
            if (nxt_io_wr[i])
                nxt_io[i] = pwdata[7:0];
        end
        // Prescale select only gates the channel 3 cascade here
        nxt_presc = (wr_go & sel[3]) ? pwdata[2:0] : presc_ff;
        nxt_mask = (wr_go & sel[8]) ? pwdata[5:0] : mask_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
                io_ff[i] <= trbio_pkg::RST_IO_CONTROL;
            io_wr_ff <= 3'h0;
            presc_ff <= trbio_pkg::RST_PRESCALE;
            mask_ff <= trbio_pkg::RST_IRQ;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                io_ff[i] <= nxt_io[i];
            io_wr_ff <= nxt_io_wr;
            presc_ff <= nxt_presc;
            mask_ff <= nxt_mask;
        end
    end

    // ******************************************************
    // Interrupt status
    // ******************************************************
    // Write one clears; a same-cycle event still sets the bit, so an
    // event is never lost to a clear that raced it
    always_comb
    begin
        nxt_stat = stat_ff;
        if (wr_go & sel[7])
            nxt_stat = stat_ff & ~pwdata[5:0];
        // Low three bits compare match, high three capture, channel 1 first
        nxt_stat[trbio_pkg::IRQ_CMP_LSB +: 3] = nxt_stat[trbio_pkg::IRQ_CMP_LSB +: 3] | cmp;
        nxt_stat[trbio_pkg::IRQ_CAP_LSB +: 3] = nxt_stat[trbio_pkg::IRQ_CAP_LSB +: 3] | cap;
        // Uses the stored mask, so a mask write shows on irq one edge late
        nxt_irq = |(nxt_stat & mask_ff);
    end

    // Registered so the interrupt line comes straight from a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_ff <= trbio_pkg::RST_IRQ;
            irq_ff <= 1'b0;
        end
        else
        begin
            stat_ff <= nxt_stat;
            irq_ff <= nxt_irq;
        end
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign ch1_pin_b_out = pin_out[0];
    assign ch1_pin_b_oe = pin_oe[0];
    assign ch2_pin_b_out = pin_out[1];
    assign ch2_pin_b_oe = pin_oe[1];
    assign ch3_pin_b_out = pin_out[2];
    assign ch3_pin_b_oe = pin_oe[2];

endmodule

`default_nettype wire

// file: rtl/trbio_pkg.sv
// Purpose: Shared constants for the timer register B I/O control block
// Assumes: APB with 32-bit data, 12-bit byte address
// Notes: Offsets are byte addresses of aligned words

package trbio_pkg;

    // ******************************************************
    // Register map
    // ******************************************************
    localparam logic [11:0] OFF_CH1_IO_CONTROL = 12'h000;
    localparam logic [11:0] OFF_CH2_IO_CONTROL = 12'h004;
    localparam logic [11:0] OFF_CH3_IO_CONTROL_HIGH = 12'h008;
    localparam logic [11:0] OFF_CH4_COUNTER_CONTROL = 12'h00c;
    localparam logic [11:0] OFF_CH1_GENERAL_REG_B = 12'h010;
    localparam logic [11:0] OFF_CH2_GENERAL_REG_B = 12'h014;
    localparam logic [11:0] OFF_CH3_GENERAL_REG_B = 12'h018;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h01c;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h020;

    // ******************************************************
    // Field layout
    // ******************************************************
    localparam int IO_FIELD_LSB = 4;
    localparam int IO_FIELD_W = 4;
    localparam int PRESCALE_W = 3;
    localparam int IRQ_W = 6;
    localparam int IRQ_CMP_LSB = 0;
    localparam int IRQ_CAP_LSB = 3;
    localparam logic [2:0] PRESCALE_UNDIVIDED = 3'h0;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // ******************************************************
    // Reset values
    // ******************************************************
    localparam logic [7:0] RST_IO_CONTROL = 8'h00;
    localparam logic [2:0] RST_PRESCALE = 3'h0;
    localparam logic [5:0] RST_IRQ = 6'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage

// file: rtl/trbio_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pin is asynchronous to pclk
// Notes: Level moves only when stages two and three agree

`timescale 1ns/1ps
`default_nettype none

module trbio_sync
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin side
    input wire logic pin_in,
    // Filtered level
    output logic level
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;
    logic nxt_lvl;

    always_comb
    begin
        nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            lvl_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign level = lvl_ff;

endmodule

`default_nettype wire

// file: rtl/trbio_chan.sv
// Purpose: One channel: register B compare or capture and its pin
// Assumes: Counter and cascade events are on pclk
// Notes: Capture beats a software write of register B in the same cycle

`timescale 1ns/1ps
`default_nettype none

module trbio_chan #(
    parameter int CNT_W = 16,
    parameter bit CAS_IGNORE = 1'b0
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic [3:0] io_field,
    input wire logic io_wr,
    input wire logic [CNT_W-1:0] counter,
    input wire logic [CNT_W-1:0] regb_wdata,
    input wire logic regb_wr,
    input wire logic pin_lvl,
    input wire logic cas_evt,
    // Results
    output logic [CNT_W-1:0] regb,
    output logic cap_evt,
    output logic cmp_evt,
    output logic pin_out,
    output logic pin_oe
);

    logic [CNT_W-1:0] regb_ff;
    logic [CNT_W-1:0] nxt_regb;
    logic [CNT_W-1:0] cnt_prev_ff;
    logic pin_prev_ff;
    logic pin_ff;
    logic nxt_pin;
    logic oe_ff;
    logic nxt_oe;
    logic cap_mode;
    logic cas_sel;
    logic rise;
    logic fall;
    logic pin_trig;
    logic [1:0] act;

    always_comb
    begin
        cap_mode = io_field[3];
        act = io_field[1:0];
        cas_sel = cap_mode & io_field[2] & ~CAS_IGNORE;
        rise = pin_lvl & ~pin_prev_ff;
        fall = ~pin_lvl & pin_prev_ff;
        if (io_field[1])
            pin_trig = rise | fall;
        else if (io_field[0])
            pin_trig = fall;
        else
            pin_trig = rise;
        cap_evt = cap_mode & (cas_sel ? cas_evt : pin_trig);
        // New match only, so a stalled counter does not toggle every cycle
        cmp_evt = ~cap_mode & (counter == regb_ff) & (cnt_prev_ff != regb_ff);
        nxt_regb = regb_ff;
        if (cap_evt)
            nxt_regb = counter;
        else if (regb_wr)
            nxt_regb = regb_wdata;
        nxt_oe = ~cap_mode & (act != trbio_pkg::ACT_NONE);
        nxt_pin = pin_ff;
        if (io_wr & nxt_oe)
            nxt_pin = io_field[2];
        else if (cmp_evt)
        begin
            unique case (act)
                trbio_pkg::ACT_NONE: nxt_pin = pin_ff;
                trbio_pkg::ACT_LOW: nxt_pin = 1'b0;
                trbio_pkg::ACT_HIGH: nxt_pin = 1'b1;
                trbio_pkg::ACT_TOGGLE: nxt_pin = ~pin_ff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            regb_ff <= '0;
            cnt_prev_ff <= '0;
            pin_prev_ff <= 1'b0;
            pin_ff <= 1'b0;
            oe_ff <= 1'b0;
        end
        else
        begin
            regb_ff <= nxt_regb;
            cnt_prev_ff <= counter;
            pin_prev_ff <= pin_lvl;
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
        end
    end

    assign regb = regb_ff;
    assign pin_out = pin_ff;
    assign pin_oe = oe_ff;

endmodule

`default_nettype wire

// file: verification/trbio_props.sv
// Purpose: Port checker for the register B I/O control block
// Assumes: One clock domain, presetn asynchronous active low
// Notes: Watches APB timing and the channel 1 pin drive

`timescale 1ns/1ps
`default_nettype none

module trbio_props
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pin
    input wire logic ch1_pin_b_out,
    input wire logic ch1_pin_b_oe
);
    // ************************************
    // Helpers
    // ************************************
    logic wr1;
    logic [3:0] fld_ff;
    assign wr1 = psel && penable && pready && pwrite && paddr == trbio_pkg::OFF_CH1_IO_CONTROL;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            fld_ff <= 4'h0;
        else
            fld_ff <= pwdata[7:4];

    // ************************************
    // Properties
    // ************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence
    pready_wait_a: assert property (setup_s |=> answer_s)
        else $error("pready not after one wait state");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    pready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    slverr_pair_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("pslverr without pready or with data");
    oe_enable_a: assert property (wr1 |-> ##2 ch1_pin_b_oe == (!$past(fld_ff[3]) && $past(fld_ff) % 4 != 0))
        else $error("pin enable wrong after io write");
    init_level_a: assert property (wr1 && !pwdata[7] && pwdata[5:4] != 2'h0 |->
        ##2 ch1_pin_b_out == $past(pwdata[6], 2))
        else $error("initial pin level wrong");
    oe_hold_a: assert property ($changed(ch1_pin_b_oe) |-> $past(wr1, 2))
        else $error("pin enable moved without io write");
    out_hold_a: assert property ($changed(ch1_pin_b_out) |-> ch1_pin_b_oe || $past(wr1, 2))
        else $error("pin level moved while disabled");
endmodule

bind trbio_top trbio_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch1_pin_b_out(ch1_pin_b_out), .ch1_pin_b_oe(ch1_pin_b_oe));

`default_nettype wire

// file: verification/trbio_pins.sv
// Purpose: External circuitry on the three register B pins
// Assumes: Far side always drives a level where the design does not
// Notes: Resolved wire feeds the design pin inputs

`timescale 1ns/1ps
`default_nettype none

module trbio_pins
(
    // Far side levels
    input wire logic [2:0] ext_lvl,
    // Design drive
    input wire logic [2:0] dut_out,
    input wire logic [2:0] dut_oe,
    // Resolved wire
    output logic [2:0] pin_lvl
);
    // Design wins where it drives, so compare outputs are seen on the wire
    assign pin_lvl = (dut_oe & dut_out) | (~dut_oe & ext_lvl);
endmodule

`default_nettype wire

// file: verification/trbio_top_tb.sv
// Purpose: Self-checking bench for the register B I/O control block
// Assumes: APB master with one idle cycle between transfers
// Notes: Pins resolved through the external circuitry model

`timescale 1ns/1ps
`default_nettype none

module trbio_top_tb;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, irq;
    logic [15:0] cnt1, cnt2, cnt3;
    logic [2:0] ext, pout, poe, plvl, ev;
    int n_fail, tests_run;

    trbio_top #(.CNT_W(16)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch1_counter(cnt1), .ch2_counter(cnt2), .ch3_counter(cnt3),
        .ch0_general_reg_c_evt(ev[2]), .ch4_counter_up(ev[1]), .ch4_counter_down(ev[0]),
        .ch1_pin_b_in(plvl[0]), .ch1_pin_b_out(pout[0]), .ch1_pin_b_oe(poe[0]),
        .ch2_pin_b_in(plvl[1]), .ch2_pin_b_out(pout[1]), .ch2_pin_b_oe(poe[1]),
        .ch3_pin_b_in(plvl[2]), .ch3_pin_b_out(pout[2]), .ch3_pin_b_oe(poe[2]), .irq(irq));
    trbio_pins u_pins (.ext_lvl(ext), .dut_out(pout), .dut_oe(poe), .pin_lvl(plvl));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ************************************
    // Tasks
    // ************************************
    task automatic tally_and_finish();
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 20)
        begin
            @(posedge pclk);
            i++;
        end
        if (pready !== 1'b1)
        begin
            n_fail++;
            $display("MISMATCH %0t no pready", $time);
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask
    // One-cycle cascade pulse, then time for the capture to land
    task automatic pulse(input logic [2:0] v);
        ev <= v;
        cyc(1);
        ev <= 3'h0;
        cyc(2);
    endtask

    // ************************************
    // Sequence
    // ************************************
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cnt1, cnt2, cnt3, ext, ev} = '0;
        n_fail = 0;
        tests_run = 0;
        presetn = 1'b0;
        cyc(12);
        presetn <= 1'b1;
        for (int a = 0; a <= 32; a += 4)
            rdchk(12'(a), 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 12'h024, 32'hff);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, trbio_pkg::OFF_CH1_GENERAL_REG_B, 32'h5);
        apb(1'b1, trbio_pkg::OFF_IRQ_MASK, 32'h1);
        for (int c = 0; c < 8; c++)
        begin
            cnt1 <= 16'h0;
            apb(1'b1, trbio_pkg::OFF_CH1_IO_CONTROL, 32'(c << 4));
            apb(1'b1, trbio_pkg::OFF_IRQ_STATUS, 32'h3f);
            chk(32'(poe[0]), 32'(c[1:0] != 2'h0));
            if (c[1:0] != 2'h0)
            begin
                chk(32'(pout[0]), 32'(c[2]));
                cnt1 <= 16'h5;
                cyc(4);
                chk(32'(pout[0]), 32'(c[1:0] == 2'h1 ? 1'b0 : c[1:0] == 2'h2 ? 1'b1 : !c[2]));
                chk(32'(irq), 32'h1);
            end
        end
        apb(1'b1, trbio_pkg::OFF_IRQ_MASK, 32'h0);
        cyc(2);
        chk(32'(irq), 32'h0);
        rdchk(trbio_pkg::OFF_IRQ_STATUS, 32'h1);
        for (int c = 8; c < 12; c++)
        begin
            apb(1'b1, trbio_pkg::OFF_CH1_GENERAL_REG_B, 32'h0);
            apb(1'b1, trbio_pkg::OFF_CH1_IO_CONTROL, 32'(c << 4));
            cnt1 <= 16'h100;
            ext[0] <= 1'b1;
            cyc(8);
            rdchk(trbio_pkg::OFF_CH1_GENERAL_REG_B, c == 9 ? 32'h0 : 32'h100);
            cnt1 <= 16'h200;
            ext[0] <= 1'b0;
            cyc(8);
            rdchk(trbio_pkg::OFF_CH1_GENERAL_REG_B, c == 8 ? 32'h100 : 32'h200);
        end
        cnt2 <= 16'habc;
        apb(1'b1, trbio_pkg::OFF_CH2_IO_CONTROL, 32'hc0);
        ext[1] <= 1'b1;
        cyc(8);
        rdchk(trbio_pkg::OFF_CH2_GENERAL_REG_B, 32'habc);
        apb(1'b1, trbio_pkg::OFF_CH1_IO_CONTROL, 32'hc0);
        cnt1 <= 16'h33;
        ext[0] <= 1'b1;
        cyc(8);
        rdchk(trbio_pkg::OFF_CH1_GENERAL_REG_B, 32'h200);
        pulse(3'h4);
        rdchk(trbio_pkg::OFF_CH1_GENERAL_REG_B, 32'h33);
        cnt3 <= 16'h77;
        apb(1'b1, trbio_pkg::OFF_CH3_IO_CONTROL_HIGH, 32'hc0);
        pulse(3'h2);
        rdchk(trbio_pkg::OFF_CH3_GENERAL_REG_B, 32'h0);
        apb(1'b1, trbio_pkg::OFF_CH4_COUNTER_CONTROL, 32'hff);
        rdchk(trbio_pkg::OFF_CH4_COUNTER_CONTROL, 32'h7);
        pulse(3'h1);
        rdchk(trbio_pkg::OFF_CH3_GENERAL_REG_B, 32'h77);
        // Compare drive on channels 2 and 3: set low and toggle
        apb(1'b1, trbio_pkg::OFF_CH2_IO_CONTROL, 32'h50);
        apb(1'b1, trbio_pkg::OFF_CH3_IO_CONTROL_HIGH, 32'h30);
        cnt2 <= 16'h0;
        cnt3 <= 16'h0;
        cyc(2);
        chk(32'({poe[2:1], pout[2:1]}), 32'hd);
        cnt2 <= 16'habc;
        cnt3 <= 16'h77;
        cyc(4);
        chk(32'(pout[2:1]), 32'h2);
        tally_and_finish();
    end
endmodule

`default_nettype wire
